// File: design/sspc_consts.vh
`ifndef SSPC_CONSTS_VH
`define SSPC_CONSTS_VH
// Serial word layout
`define SSPC_WORD_W        21
`define SSPC_ADDR_W        4
`define SSPC_DATA_W        17
// Latch addresses
`define SSPC_ADDR_TEST     4'h0
`define SSPC_ADDR_CTRL     4'h1
`define SSPC_ADDR_MAIN     4'h4
`define SSPC_ADDR_REF      4'h5
// Control latch field positions within the data field
`define SSPC_CTRL_OOL_BIT  12
`define SSPC_CTRL_CR1_BIT  10
`define SSPC_CTRL_CR0_BIT  9
`define SSPC_CTRL_SPD_BIT  6
// Divider ranges and reset values
`define SSPC_MAIN_MIN      17'h0_0200
`define SSPC_MAIN_RST      17'h0_0200
`define SSPC_REF_W         11
`define SSPC_REF_MIN       11'h002
`define SSPC_REF_RST       11'h002
`define SSPC_CTRL_RST      17'h1_0040
// AHB-Lite register byte offsets
`define SSPC_REG_CTRL      8'h00
`define SSPC_REG_MAIN      8'h04
`define SSPC_REG_REF       8'h08
`define SSPC_REG_STAT      8'h0C
`endif

// File: design/sspc_sync.v
`timescale 1ns/1ns
`default_nettype none
module sspc_sync
(
    input  wire       clk_sys_i,
    input  wire       sys_rst_i,
    input  wire       async_i,
    output wire       sync_o
);
    reg meta_q;
    reg sync_q;
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end
    assign sync_o = sync_q;
endmodule
`default_nettype wire

// File: design/sspc_divider.v
`timescale 1ns/1ns
`default_nettype none
// Down counter, one-cycle terminal pulse, held at its start while halted
module sspc_divider
#(
    parameter W = 17
)
(
    input  wire         clk_sys_i,
    input  wire         sys_rst_i,
    input  wire         run_i,
    input  wire         tick_i,
    input  wire [W-1:0] ratio_i,
    output wire         tc_o
);
    reg [W-1:0] cnt_q;
    reg         tc_q;
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i || !run_i)
        begin
            cnt_q <= ratio_i - {{(W-1){1'b0}}, 1'b1};
            tc_q  <= 1'b0;
        end
        else
        begin
            tc_q <= 1'b0;
            if (tick_i)
            begin
                if (cnt_q == {W{1'b0}})
                begin
                    cnt_q <= ratio_i - {{(W-1){1'b0}}, 1'b1};
                    tc_q  <= 1'b1;
                end
                else
                begin
                    cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
    assign tc_o = tc_q;
endmodule
`default_nettype wire

// File: design/sspc_top.v
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "sspc_consts.vh"
// Behaviour
// - Three host-driven input lines: data, clock, active-low enable; nothing driven back.
// - Clock edges while enable is high leave the shift register unchanged.
// - Enable rising loads the word into the latch its address selects.
// - Shift register keeps only the latest 21 bits shifted in.
// - Any number of clocks accepted; leading surplus bits fall out.
// - Serial capture keeps working during power-down.
// - Hardware power-down stops both dividers and the phase comparator.
// - Normal pump active always except in power-down.
// - Speed-up pump enabled only while speed-up request is asserted.
// - Speed-up request changes take effect only at comparison cycle start.
// - Pump current ratio field is written over the serial bus.
// - Open-drain lock output pulls low for the measured phase error.
// - Lock pulse output disabled when its serial enable bit is cleared.
// - Main divider supports ratios 512 to 131071.
// - Phase/frequency detector compares dividers and steers both pumps.
// - Both divider ratios are loaded only through the serial bus.
// - Words MSB first; last four bits address, earlier bits data.
// - Dividers run only when both power-down controls are zero.
// - Leaving power-down restarts both dividers together.
// - Ratio field 00,01,10,11 selects 4,8,12,16 to one.
module sspc_top
(
    input  wire        clk_sys_i,
    input  wire        sys_rst_i,
    input  wire        prog_data_i,
    input  wire        prog_clk_i,
    input  wire        prog_en_n_i,
    input  wire        hw_powerdown_in_i,
    input  wire        speedup_req_i,
    input  wire        ref_clock_in_i,
    input  wire        rf_divider_in_i,
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output reg  [31:0] hrdata_o,
    output reg         hreadyout_o,
    output reg         hresp_o,
    output reg         normal_pump_up_o,
    output reg         normal_pump_dn_o,
    output reg         speedup_pump_up_o,
    output reg         speedup_pump_dn_o,
    output reg  [4:0]  pump_ratio_o,
    output reg         lock_o,
    output reg         lock_oe_n_o,
    output reg         powered_down_o
);
    //------------------------------------------------------------
    // Input synchronisers
    //------------------------------------------------------------
    wire data_s;
    wire sclk_s;
    wire en_n_s;
    wire hwpd_s;
    wire fast_s;
    wire refc_s;
    wire rfc_s;
    wire [6:0] async_in;
    wire [6:0] sync_out;
    assign async_in = {rf_divider_in_i, ref_clock_in_i, speedup_req_i,
                       hw_powerdown_in_i, ~prog_en_n_i, prog_clk_i, prog_data_i};
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1)
        begin : g_sync
            sspc_sync u_sync
            (
                .clk_sys_i (clk_sys_i),
                .sys_rst_i (sys_rst_i),
                .async_i   (async_in[gi]),
                .sync_o    (sync_out[gi])
            );
        end
    endgenerate
    assign data_s = sync_out[0];
    assign sclk_s = sync_out[1];
    // Enable travels inverted: a synchroniser reset to 0
    // then reads as an idle bus, so no false load edge
    assign en_n_s = ~sync_out[2];
    assign hwpd_s = sync_out[3];
    assign fast_s = sync_out[4];
    assign refc_s = sync_out[5];
    assign rfc_s  = sync_out[6];

    //------------------------------------------------------------
    // Edge detection
    //------------------------------------------------------------
    reg sclk_prev_q;
    reg en_prev_q;
    reg refc_prev_q;
    reg rfc_prev_q;
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            sclk_prev_q <= 1'b0;
            en_prev_q   <= 1'b1;
            refc_prev_q <= 1'b0;
            rfc_prev_q  <= 1'b0;
        end
        else
        begin
            sclk_prev_q <= sclk_s;
            en_prev_q   <= en_n_s;
            refc_prev_q <= refc_s;
            rfc_prev_q  <= rfc_s;
        end
    end
    wire sclk_rise = sclk_s & ~sclk_prev_q;
    wire en_rise   = en_n_s & ~en_prev_q;
    wire ref_tick  = refc_s & ~refc_prev_q;
    wire rf_tick   = rfc_s & ~rfc_prev_q;

    //------------------------------------------------------------
    // Serial shift register
    //------------------------------------------------------------
    reg  [`SSPC_WORD_W-1:0] shift_q;
    // Oldest bit drops off the top
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            shift_q <= {`SSPC_WORD_W{1'b0}};
        else if (sclk_rise && !en_n_s)
            shift_q <= {shift_q[`SSPC_WORD_W-2:0], data_s};
    end
    wire [`SSPC_ADDR_W-1:0] word_addr = shift_q[`SSPC_ADDR_W-1:0];
    wire [`SSPC_DATA_W-1:0] word_data = shift_q[`SSPC_WORD_W-1:`SSPC_ADDR_W];

    //------------------------------------------------------------
    // Latches
    //------------------------------------------------------------
    reg [`SSPC_DATA_W-1:0] ctrl_q;
    reg [`SSPC_DATA_W-1:0] main_q;
    reg [`SSPC_REF_W-1:0]  ref_q;
    reg [`SSPC_DATA_W-1:0] test_q;
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            ctrl_q <= `SSPC_CTRL_RST;
            main_q <= `SSPC_MAIN_RST;
            ref_q  <= `SSPC_REF_RST;
            test_q <= {`SSPC_DATA_W{1'b0}};
        end
        else if (en_rise)
        begin
            case (word_addr)
                `SSPC_ADDR_TEST: test_q <= word_data;
                `SSPC_ADDR_CTRL: ctrl_q <= word_data;
                `SSPC_ADDR_MAIN: main_q <= word_data;
                `SSPC_ADDR_REF:  ref_q  <= word_data[`SSPC_REF_W-1:0];
                default:         test_q <= test_q;
            endcase
        end
    end
    wire       ool_en  = ctrl_q[`SSPC_CTRL_OOL_BIT];
    wire [1:0] cr_sel  = {ctrl_q[`SSPC_CTRL_CR1_BIT], ctrl_q[`SSPC_CTRL_CR0_BIT]};
    wire       sw_powerdown_bit = ctrl_q[`SSPC_CTRL_SPD_BIT];

    //------------------------------------------------------------
    // Power-down and dividers
    //------------------------------------------------------------
    // Hardware input stops dividers
    wire pd = hwpd_s | sw_powerdown_bit;
    wire [`SSPC_DATA_W-1:0] main_ratio = (main_q < `SSPC_MAIN_MIN) ? `SSPC_MAIN_MIN : main_q;
    wire [`SSPC_REF_W-1:0]  ref_ratio  = (ref_q < `SSPC_REF_MIN) ? `SSPC_REF_MIN : ref_q;
    wire main_tc;
    wire ref_tc;
    // Shared run level restarts both together
    // Held at start count while down
    sspc_divider #(.W(`SSPC_DATA_W)) u_main
    (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .run_i     (~pd),
        .tick_i    (rf_tick),
        .ratio_i   (main_ratio),
        .tc_o      (main_tc)
    );
    sspc_divider #(.W(`SSPC_REF_W)) u_ref
    (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .run_i     (~pd),
        .tick_i    (ref_tick),
        .ratio_i   (ref_ratio),
        .tc_o      (ref_tc)
    );

    //------------------------------------------------------------
    // Phase/frequency detector
    //------------------------------------------------------------
    reg up_q;
    reg dn_q;
    reg fast_q;
    // Reference leads gives up, main leads gives down
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i || pd)
        begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end
        else
        begin
            if ((up_q | ref_tc) & (dn_q | main_tc))
            begin
                up_q <= 1'b0;
                dn_q <= 1'b0;
            end
            else
            begin
                up_q <= up_q | ref_tc;
                dn_q <= dn_q | main_tc;
            end
        end
    end
    // Fast request sampled only between comparisons
    // A pending pulse keeps the old gate to its end
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            fast_q <= 1'b0;
        else if (!up_q && !dn_q)
            fast_q <= fast_s;
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    // Ratio as multiple of normal current, 4 to 16
    function [4:0] ratio_of;
        input [1:0] sel;
        begin
            ratio_of = {1'b0, sel, 2'b00} + 5'h04;
        end
    endfunction
    // Pump gate shared by the four pump drive outputs and the lock enable
    function pump_drive;
        input active;
        input gate;
        input down;
        begin
            pump_drive = active & gate & ~down;
        end
    endfunction
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            normal_pump_up_o  <= 1'b0;
            normal_pump_dn_o  <= 1'b0;
            speedup_pump_up_o <= 1'b0;
            speedup_pump_dn_o <= 1'b0;
            pump_ratio_o      <= 5'h04;
            powered_down_o    <= 1'b0;
        end
        else
        begin
            // Normal pump off only in power-down
            normal_pump_up_o  <= pump_drive(up_q, 1'b1, pd);
            normal_pump_dn_o  <= pump_drive(dn_q, 1'b1, pd);
            speedup_pump_up_o <= pump_drive(up_q, fast_q, pd);
            speedup_pump_dn_o <= pump_drive(dn_q, fast_q, pd);
            pump_ratio_o      <= ratio_of(cr_sel);
            powered_down_o    <= pd;
        end
    end

    //------------------------------------------------------------
    // Lock detect output
    //------------------------------------------------------------
    // Pull low during phase error
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            lock_o      <= 1'b0;
            lock_oe_n_o <= 1'b1;
        end
        else
        begin
            // Open drain: pin only ever pulled low
            lock_o      <= 1'b0;
            // Gated by power-down so no stale pulse leaks out
            lock_oe_n_o <= ~pump_drive(up_q | dn_q, ool_en, pd);
        end
    end

    //------------------------------------------------------------
    // AHB-Lite read-only status
    //------------------------------------------------------------
    // Registers mirror latches; writes ignored so ratios stay serial-only
    reg       dphase_q;
    reg [7:0] addr_q;
    wire      take = hsel_i & htrans_i[1] & hready_i;
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            dphase_q    <= 1'b0;
            addr_q      <= 8'h00;
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
        else
        begin
            dphase_q <= take;
            if (take)
            begin
                addr_q <= haddr_i[7:0];
                case (haddr_i[7:0])
                    `SSPC_REG_CTRL: hrdata_o <= {15'h0000, ctrl_q};
                    `SSPC_REG_MAIN: hrdata_o <= {15'h0000, main_q};
                    `SSPC_REG_REF:  hrdata_o <= {21'h00_0000, ref_q};
                    `SSPC_REG_STAT: hrdata_o <= {28'h000_0000, fast_q, dn_q, up_q, pd};
                    default:        hrdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end
    wire unused_ok = &{1'b0, dphase_q, addr_q, hwrite_i, hsize_i, hwdata_i, test_q, haddr_i[31:8]};
endmodule
`default_nettype wire

// File: sim/sspc_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module sspc_asserts
(
    input wire logic       clk_sys_i,
    input wire logic       sys_rst_i,
    input wire logic       hw_powerdown_in_i,
    input wire logic       hreadyout_o,
    input wire logic       hresp_o,
    input wire logic       normal_pump_up_o,
    input wire logic       normal_pump_dn_o,
    input wire logic       speedup_pump_up_o,
    input wire logic       speedup_pump_dn_o,
    input wire logic [4:0] pump_ratio_o,
    input wire logic       lock_oe_n_o,
    input wire logic       powered_down_o
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // Slack for the input synchronisers
    sequence pd_held_s;
        powered_down_o [*3];
    endsequence
    sequence hw_pd_held_s;
        hw_powerdown_in_i [*6];
    endsequence
    ready_high_a: assert property (hreadyout_o)
        else $error("bus stalled");
    resp_okay_a: assert property (!hresp_o)
        else $error("error response");
    hw_pd_stops_a: assert property (hw_pd_held_s |-> powered_down_o)
        else $error("not powered down");
    pd_pump_off_a: assert property (pd_held_s |-> !normal_pump_up_o && !normal_pump_dn_o)
        else $error("pump active while down");
    pd_lock_off_a: assert property (pd_held_s |-> lock_oe_n_o)
        else $error("lock pulse while down");
    fast_follows_a: assert property ((speedup_pump_up_o || speedup_pump_dn_o) |->
        speedup_pump_up_o == normal_pump_up_o && speedup_pump_dn_o == normal_pump_dn_o)
        else $error("fast pump differs");
    ratio_legal_a: assert property (pump_ratio_o inside {5'h04, 5'h08, 5'h0C, 5'h10})
        else $error("bad pump ratio");
    lock_cause_a: assert property (!lock_oe_n_o |-> normal_pump_up_o || normal_pump_dn_o
        || $past(normal_pump_up_o) || $past(normal_pump_dn_o))
        else $error("lock pulse without error");
endmodule
bind sspc_top sspc_asserts u_chk (.*);
`default_nettype wire

// File: sim/sspc_host.sv
`timescale 1ns/1ns
`default_nettype none
module sspc_host
(
    output var logic dat_o,
    output var logic sck_o,
    output var logic en_n_o
);
    // ----
    // Host end of the serial bus
    // ----
    // three lines, clock idles low
    initial
    begin
        dat_o = 1'h0;
        sck_o = 1'h0;
        en_n_o = 1'h1;
    end
    // data set ahead of the rising edge
    task automatic put(input logic b);
        dat_o = b;
        #62 sck_o = 1'h1;
        #63 sck_o = 1'h0;
    endtask
    // surplus leading bits, then MSB first
    task automatic send(input logic [16:0] v, input logic [3:0] a, input logic [3:0] lead);
        en_n_o = 1'h0;
        for (int i = 0; i < lead; i++)
            put(i[0]);
        for (int i = 20; i >= 0; i--)
            put(i > 3 ? v[i-4] : a[i]);
        #62 en_n_o = 1'h1;
        // Released line shows the inverse, never a held bit
        dat_o = ~dat_o;
        #250;
    endtask
    // bits clocked with enable high, then an empty frame
    task automatic stray(input logic [3:0] pat);
        for (int i = 3; i >= 0; i--)
            put(pat[i]);
        #62 en_n_o = 1'h0;
        #250 en_n_o = 1'h1;
        #250;
    endtask
endmodule
`default_nettype wire

// File: sim/sspc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "sspc_consts.vh"
module sspc_top_tb;
    logic        clk_sys_i = 1'h0;
    logic        sys_rst_i = 1'h1;
    logic        hsel_i = 1'h0;
    logic        hwrite_i = 1'h0;
    logic [1:0]  htrans_i = 2'h0;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic        hw_powerdown_in_i = 1'h0;
    logic        speedup_req_i = 1'h0;
    logic        ref_clock_in_i = 1'h0;
    logic        rf_divider_in_i = 1'h0;
    logic [2:0]  rf_q = 3'h0;
    logic [31:0] d;
    wire  [31:0] hrdata_o;
    wire  [4:0]  pump_ratio_o;
    wire         hreadyout_o, lock_oe_n_o, powered_down_o, prog_data_i, prog_clk_i, prog_en_n_i;
    wire         normal_pump_up_o, normal_pump_dn_o, speedup_pump_up_o, speedup_pump_dn_o;
    wire         hresp_o, lock_o;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          np, sp, lk;
    // ----
    // Bench
    // ----
    sspc_host host (.dat_o(prog_data_i), .sck_o(prog_clk_i), .en_n_o(prog_en_n_i));
    sspc_top dut (.*, .hsize_i(3'h2), .hready_i(hreadyout_o));
    always #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i)
    begin
        rf_q <= (rf_q == 3'h5) ? 3'h0 : rf_q + 3'h1;
        rf_divider_in_i <= rf_q < 3'h3;
        ref_clock_in_i <= (rf_q == 3'h5) ? ~ref_clock_in_i : ref_clock_in_i;
    end
    task automatic final_report();
        $display("Mismatches %0d, checks %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rdy();
        for (int n = 0; n < 20; n++)
        begin
            @(posedge clk_sys_i);
            if (hreadyout_o === 1'h1)
                return;
        end
        n_mismatch++;
        final_report();
    endtask
    task automatic ahb(input logic [31:0] a, input logic wr, input logic [31:0] wd);
        @(posedge clk_sys_i);
        hsel_i <= 1'h1;
        haddr_i <= a;
        hwrite_i <= wr;
        htrans_i <= 2'h2;
        rdy();
        hsel_i <= 1'h0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        rdy();
        d = hrdata_o;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        ahb(a, 1'h0, 32'h0);
        check($sformatf("reg %h", a), d, exp);
    endtask
    // Pump and lock activity over a window
    task automatic watch(input int n);
        np = 0;
        sp = 0;
        lk = 0;
        repeat (n)
        begin
            @(posedge clk_sys_i);
            np += normal_pump_up_o | normal_pump_dn_o;
            sp += speedup_pump_up_o | speedup_pump_dn_o;
            lk += !lock_oe_n_o;
        end
    endtask
    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        sys_rst_i <= 1'h0;
        repeat (3) @(posedge clk_sys_i);
        rd(`SSPC_REG_CTRL, 32'h1_0040);
        rd(`SSPC_REG_REF, 32'h2);
        rd(32'h10, 32'h0);
        check("lock level", lock_o, 1'h0);
        check("resp", hresp_o, 1'h0);
        ahb(`SSPC_REG_MAIN, 1'h1, 32'h1234);
        rd(`SSPC_REG_MAIN, 32'h200);
        host.send(17'h1_FFFF, `SSPC_ADDR_MAIN, 4'h3);
        rd(`SSPC_REG_MAIN, 32'h1_FFFF);
        host.send(17'h12C, `SSPC_ADDR_REF, 4'h0);
        host.stray(`SSPC_ADDR_MAIN);
        rd(`SSPC_REG_MAIN, 32'h1_FFFF);
        rd(`SSPC_REG_REF, 32'h12C);
        host.send(17'h200, `SSPC_ADDR_MAIN, 4'h0);
        for (int cr = 0; cr < 4; cr++)
        begin
            host.send({5'h01, 1'h0, cr[1:0], 9'h000}, `SSPC_ADDR_CTRL, 4'h0);
            check("ratio", pump_ratio_o, 4 * cr + 4);
        end
        check("pd", powered_down_o, 1'h0);
        @(posedge clk_sys_i);
        speedup_req_i <= 1'h1;
        watch(6000);
        check("pulses", {np > 0, sp > 0, lk > 0}, 3'h7);
        @(posedge clk_sys_i);
        speedup_req_i <= 1'h0;
        watch(4000);
        watch(6000);
        check("fast", sp, 0);
        host.send(17'h0, `SSPC_ADDR_CTRL, 4'h0);
        watch(6000);
        check("lock", lk, 0);
        @(posedge clk_sys_i);
        hw_powerdown_in_i <= 1'h1;
        watch(10);
        watch(3000);
        check("pd pumps", np, 0);
        rd(`SSPC_REG_STAT, 32'h1);
        host.send(17'h300, `SSPC_ADDR_MAIN, 4'h0);
        rd(`SSPC_REG_MAIN, 32'h300);
        @(posedge clk_sys_i);
        hw_powerdown_in_i <= 1'h0;
        watch(6000);
        check("restart", np > 0, 1'h1);
        final_report();
    end
endmodule
`default_nettype wire
